//--- core/ep0_autosend_pkg.sv
package ep0_autosend_pkg;
  // register offsets on the 8-bit software port
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_PTR_HIGH   = 8'h01;
  localparam logic [7:0] ADDR_PTR_LOW    = 8'h02;
  localparam logic [7:0] ADDR_XLEN_LOW   = 8'h03;
  localparam logic [7:0] ADDR_XLEN_HIGH  = 8'h04;
  localparam logic [7:0] ADDR_BCNT_LOW   = 8'h05;
  localparam logic [7:0] ADDR_BCNT_HIGH  = 8'h06;
  localparam logic [7:0] ADDR_SETUP_BASE = 8'h08;
  localparam logic [7:0] ADDR_BUF_BASE   = 8'h40;
  // control register fields
  localparam int CTRL_NAK_HOLD_BIT  = 0;
  localparam int CTRL_AUTO_LEN_BIT  = 1;
  localparam int CTRL_BUSY_BIT      = 2;
  localparam logic CTRL_AUTO_LEN_RST = 1'b1;
  // setup packet layout and descriptor type codes
  localparam int SETUP_BYTES        = 8;
  localparam logic [2:0] SETUP_LEN_LOW  = 3'h6;
  localparam logic [2:0] SETUP_LEN_HIGH = 3'h7;
  localparam logic [7:0] DESC_TYPE_CONFIG      = 8'h02;
  localparam logic [7:0] DESC_TYPE_OTHER_SPEED = 8'h07;
  // descriptor header bytes read to find the real length
  localparam logic [2:0] HDR_READS  = 3'h4;
  localparam logic [6:0] MAX_PACKET = 7'h40;
  typedef enum logic [6:0] {
    S_IDLE   = 7'b0000001,
    S_LEN    = 7'b0000010,
    S_FETCH  = 7'b0000100,
    S_READY  = 7'b0001000,
    S_SEND   = 7'b0010000,
    S_WAIT   = 7'b0100000,
    S_STATUS = 7'b1000000
  } xfer_state_t;
endpackage

//--- core/ep0_descriptor_autosend.sv
// Functional notes
// - store eight setup bytes, then raise irq
// - pointer low write starts automatic transfer
// - split data into packets of 64 max
// - requested count from setup bytes 6, 7
// - read descriptor length field at pointer
// - send minimum of requested and actual
// - fetch from memory into endpoint buffer
// - resend data packet the host missed
// - ACK status stage after final packet
// - setup and IN irqs keep firing
// - vendor IN requests served the same way
// - explicit length when setup lacks it
// - manual buffer fill plus byte count send
// - pointer is 16 bits, two byte registers
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ep0_descriptor_autosend #(
  parameter int ADDR_W = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              setup_wr,
  input  wire logic [2:0]        setup_idx,
  input  wire logic [7:0]        setup_data,
  input  wire logic              setup_end,
  input  wire logic              in_token,
  input  wire logic              hs_ack,
  input  wire logic              hs_timeout,
  input  wire logic              status_token,
  output logic                   tx_valid,
  output logic      [7:0]        tx_data,
  output logic                   tx_last,
  input  wire logic              tx_ready,
  output logic                   tx_zlp,
  output logic                   in_nak,
  output logic                   status_ack,
  output logic                   status_nak,
  output logic                   setup_received_irq,
  output logic                   ep_zero_in_irq,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic                   mem_rd,
  input  wire logic [7:0]        mem_rdata
);
  initial
  begin
    if (ADDR_W != 16)
      $error("descriptor pointer is two byte registers, ADDR_W must be 16");
  end

  logic [7:0]  setup_packet_ram [0:ep0_autosend_pkg::SETUP_BYTES-1];
  logic [7:0]  ep_zero_buffer [0:63];
  logic [7:0]  desc_pointer_high_reg;
  logic [7:0]  desc_pointer_low_reg;
  logic [7:0]  xlen_low_reg;
  logic [7:0]  xlen_high_reg;
  logic [7:0]  bcnt_high_reg;
  logic        handshake_nak_hold_reg;
  logic        desc_pointer_auto_length_reg;
  ep0_autosend_pkg::xfer_state_t state_reg;
  logic [15:0] base_reg;
  logic [15:0] offset_reg;
  logic [15:0] remain_reg;
  logic [15:0] total_reg;
  logic [15:0] request_reg;
  logic [6:0]  pkt_len_reg;
  logic [6:0]  issue_reg;
  logic [6:0]  idx_reg;
  logic        manual_reg;
  logic        rd_pend_reg;
  logic [6:0]  rd_tag_reg;
  logic [7:0]  hdr_reg [0:3];
  logic [7:0]  reg_rdata_reg;

  wire wr_ctrl  = reg_wr && reg_addr == ep0_autosend_pkg::ADDR_CTRL;
  wire wr_plow  = reg_wr && reg_addr == ep0_autosend_pkg::ADDR_PTR_LOW;
  wire wr_bcnt  = reg_wr && reg_addr == ep0_autosend_pkg::ADDR_BCNT_LOW;
  wire wr_buf   = reg_wr && reg_addr[7:6] == ep0_autosend_pkg::ADDR_BUF_BASE[7:6];
  wire idle_now = state_reg == ep0_autosend_pkg::S_IDLE;
  wire [15:0] setup_len = {setup_packet_ram[ep0_autosend_pkg::SETUP_LEN_HIGH],
                           setup_packet_ram[ep0_autosend_pkg::SETUP_LEN_LOW]};
  wire        hdr_long  = hdr_reg[1] == ep0_autosend_pkg::DESC_TYPE_CONFIG ||
                          hdr_reg[1] == ep0_autosend_pkg::DESC_TYPE_OTHER_SPEED;
  wire [15:0] actual_len = hdr_long ? {hdr_reg[3], hdr_reg[2]} : {8'h00, hdr_reg[0]};
  wire [15:0] after_pkt  = remain_reg - {9'h000, pkt_len_reg};

  function automatic logic [6:0] pkt_of(input logic [15:0] left);
    pkt_of = (left > {9'h000, ep0_autosend_pkg::MAX_PACKET}) ?
             ep0_autosend_pkg::MAX_PACKET : left[6:0];
  endfunction

  // setup bytes land before the irq pulse, one cycle apart at least
  always_ff @(posedge sys_clk)
  begin
    if (setup_wr)
      setup_packet_ram[setup_idx] <= setup_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      setup_received_irq <= 1'b0;
    else
      setup_received_irq <= setup_end;
  end

  // setup arrival wins over a same-cycle firmware clear
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      handshake_nak_hold_reg <= 1'b0;
    else if (setup_end)
      handshake_nak_hold_reg <= 1'b1;
    else if (wr_ctrl && reg_wdata[ep0_autosend_pkg::CTRL_NAK_HOLD_BIT])
      handshake_nak_hold_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      desc_pointer_auto_length_reg <= ep0_autosend_pkg::CTRL_AUTO_LEN_RST;
      desc_pointer_high_reg        <= 8'h00;
      desc_pointer_low_reg         <= 8'h00;
      xlen_low_reg                 <= 8'h00;
      xlen_high_reg                <= 8'h00;
      bcnt_high_reg                <= 8'h00;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ep0_autosend_pkg::ADDR_CTRL:
          desc_pointer_auto_length_reg <= reg_wdata[ep0_autosend_pkg::CTRL_AUTO_LEN_BIT];
        ep0_autosend_pkg::ADDR_PTR_HIGH:  desc_pointer_high_reg <= reg_wdata;
        ep0_autosend_pkg::ADDR_PTR_LOW:   desc_pointer_low_reg  <= reg_wdata;
        ep0_autosend_pkg::ADDR_XLEN_LOW:  xlen_low_reg  <= reg_wdata;
        ep0_autosend_pkg::ADDR_XLEN_HIGH: xlen_high_reg <= reg_wdata;
        ep0_autosend_pkg::ADDR_BCNT_HIGH: bcnt_high_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // fetched data has priority; firmware should not touch the buffer while busy
  always_ff @(posedge sys_clk)
  begin
    if (rd_pend_reg && state_reg == ep0_autosend_pkg::S_FETCH)
      ep_zero_buffer[rd_tag_reg[5:0]] <= mem_rdata;
    else if (wr_buf)
      ep_zero_buffer[reg_addr[5:0]] <= reg_wdata;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rd_pend_reg && state_reg == ep0_autosend_pkg::S_LEN)
      hdr_reg[rd_tag_reg[1:0]] <= mem_rdata;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      reg_rdata_reg <= 8'h00;
    else if (!reg_rd)
      reg_rdata_reg <= 8'h00;
    else if (reg_addr[7:3] == ep0_autosend_pkg::ADDR_SETUP_BASE[7:3])
      reg_rdata_reg <= setup_packet_ram[reg_addr[2:0]];
    else if (reg_addr[7:6] == ep0_autosend_pkg::ADDR_BUF_BASE[7:6])
      reg_rdata_reg <= ep_zero_buffer[reg_addr[5:0]];
    else
    begin
      case (reg_addr)
        ep0_autosend_pkg::ADDR_CTRL: reg_rdata_reg <= {5'h00, !idle_now,
          desc_pointer_auto_length_reg, handshake_nak_hold_reg};
        ep0_autosend_pkg::ADDR_PTR_HIGH:  reg_rdata_reg <= desc_pointer_high_reg;
        ep0_autosend_pkg::ADDR_PTR_LOW:   reg_rdata_reg <= desc_pointer_low_reg;
        ep0_autosend_pkg::ADDR_XLEN_LOW:  reg_rdata_reg <= xlen_low_reg;
        ep0_autosend_pkg::ADDR_XLEN_HIGH: reg_rdata_reg <= xlen_high_reg;
        ep0_autosend_pkg::ADDR_BCNT_LOW:  reg_rdata_reg <= {1'b0, pkt_len_reg};
        ep0_autosend_pkg::ADDR_BCNT_HIGH: reg_rdata_reg <= bcnt_high_reg;
        default: reg_rdata_reg <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = reg_rdata_reg;

  // status stage: ACK only once the data stage is over and the hold is released
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      status_ack <= 1'b0;
      status_nak <= 1'b0;
    end
    else
    begin
      status_ack <= status_token && !handshake_nak_hold_reg && !setup_end &&
                    (idle_now || state_reg == ep0_autosend_pkg::S_STATUS);
      status_nak <= status_token && (handshake_nak_hold_reg || setup_end ||
                    !(idle_now || state_reg == ep0_autosend_pkg::S_STATUS));
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_reg      <= ep0_autosend_pkg::S_IDLE;
      base_reg       <= 16'h0000;
      offset_reg     <= 16'h0000;
      remain_reg     <= 16'h0000;
      total_reg      <= 16'h0000;
      request_reg    <= 16'h0000;
      pkt_len_reg    <= 7'h00;
      issue_reg      <= 7'h00;
      idx_reg        <= 7'h00;
      manual_reg     <= 1'b0;
      rd_pend_reg    <= 1'b0;
      rd_tag_reg     <= 7'h00;
      mem_rd         <= 1'b0;
      mem_addr       <= '0;
      tx_valid       <= 1'b0;
      tx_data        <= 8'h00;
      tx_last        <= 1'b0;
      tx_zlp         <= 1'b0;
      in_nak         <= 1'b0;
      ep_zero_in_irq <= 1'b0;
    end
    else
    begin
      rd_pend_reg    <= mem_rd;
      // issue_reg has already stepped past the read that is now returning
      rd_tag_reg     <= issue_reg - 7'h01;
      mem_rd         <= 1'b0;
      tx_zlp         <= 1'b0;
      in_nak         <= in_token && state_reg != ep0_autosend_pkg::S_READY;
      ep_zero_in_irq <= 1'b0;
      if (setup_end)
      begin
        // a new setup aborts whatever data stage was running
        state_reg <= ep0_autosend_pkg::S_IDLE;
        tx_valid  <= 1'b0;
      end
      else
      begin
        case (state_reg)
          ep0_autosend_pkg::S_IDLE:
          begin
            if (wr_plow)
            begin
              base_reg    <= {desc_pointer_high_reg, reg_wdata};
              offset_reg  <= 16'h0000;
              request_reg <= setup_len;
              issue_reg   <= 7'h00;
              manual_reg  <= 1'b0;
              if (desc_pointer_auto_length_reg)
                state_reg <= ep0_autosend_pkg::S_LEN;
              else
              begin
                total_reg   <= {xlen_high_reg, xlen_low_reg};
                remain_reg  <= {xlen_high_reg, xlen_low_reg};
                pkt_len_reg <= pkt_of({xlen_high_reg, xlen_low_reg});
                state_reg   <= ep0_autosend_pkg::S_FETCH;
              end
            end
            else if (wr_bcnt)
            begin
              pkt_len_reg <= (reg_wdata > {1'b0, ep0_autosend_pkg::MAX_PACKET}) ?
                             ep0_autosend_pkg::MAX_PACKET : reg_wdata[6:0];
              manual_reg  <= 1'b1;
              state_reg   <= ep0_autosend_pkg::S_READY;
            end
          end
          ep0_autosend_pkg::S_LEN:
          begin
            if (issue_reg < {4'h0, ep0_autosend_pkg::HDR_READS})
            begin
              mem_rd    <= 1'b1;
              mem_addr  <= base_reg + {9'h000, issue_reg};
              issue_reg <= issue_reg + 7'h01;
            end
            else if (!mem_rd && !rd_pend_reg)
            begin
              total_reg   <= (request_reg < actual_len) ? request_reg : actual_len;
              remain_reg  <= (request_reg < actual_len) ? request_reg : actual_len;
              pkt_len_reg <= pkt_of((request_reg < actual_len) ? request_reg : actual_len);
              issue_reg   <= 7'h00;
              state_reg   <= ep0_autosend_pkg::S_FETCH;
            end
          end
          ep0_autosend_pkg::S_FETCH:
          begin
            if (issue_reg < pkt_len_reg)
            begin
              mem_rd    <= 1'b1;
              mem_addr  <= base_reg + offset_reg + {9'h000, issue_reg};
              issue_reg <= issue_reg + 7'h01;
            end
            else if (!mem_rd && !rd_pend_reg)
              state_reg <= ep0_autosend_pkg::S_READY;
          end
          ep0_autosend_pkg::S_READY:
          begin
            if (in_token)
            begin
              idx_reg <= 7'h00;
              if (pkt_len_reg == 7'h00)
              begin
                tx_zlp    <= 1'b1;
                state_reg <= ep0_autosend_pkg::S_WAIT;
              end
              else
                state_reg <= ep0_autosend_pkg::S_SEND;
            end
          end
          ep0_autosend_pkg::S_SEND:
          begin
            if (tx_valid && tx_ready && tx_last)
            begin
              tx_valid  <= 1'b0;
              tx_last   <= 1'b0;
              state_reg <= ep0_autosend_pkg::S_WAIT;
            end
            else if (!tx_valid || tx_ready)
            begin
              tx_valid <= 1'b1;
              tx_data  <= ep_zero_buffer[idx_reg[5:0]];
              tx_last  <= idx_reg == pkt_len_reg - 7'h01;
              idx_reg  <= idx_reg + 7'h01;
            end
          end
          ep0_autosend_pkg::S_WAIT:
          begin
            if (hs_timeout)
              state_reg <= ep0_autosend_pkg::S_READY;
            else if (hs_ack)
            begin
              ep_zero_in_irq <= 1'b1;
              offset_reg     <= offset_reg + {9'h000, pkt_len_reg};
              remain_reg     <= after_pkt;
              issue_reg      <= 7'h00;
              if (manual_reg)
                state_reg <= ep0_autosend_pkg::S_STATUS;
              else if (after_pkt != 16'h0000)
              begin
                pkt_len_reg <= pkt_of(after_pkt);
                state_reg   <= ep0_autosend_pkg::S_FETCH;
              end
              // a short total ending on a full packet needs a zero-length end
              else if (pkt_len_reg == ep0_autosend_pkg::MAX_PACKET && total_reg < request_reg)
              begin
                pkt_len_reg <= 7'h00;
                state_reg   <= ep0_autosend_pkg::S_READY;
              end
              else
                state_reg <= ep0_autosend_pkg::S_STATUS;
            end
          end
          ep0_autosend_pkg::S_STATUS:
          begin
            if (status_token && !handshake_nak_hold_reg)
              state_reg <= ep0_autosend_pkg::S_IDLE;
          end
          default: state_reg <= ep0_autosend_pkg::S_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/ep0_autosend_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ep0_autosend_chk #(
  parameter int ADDR_W = 16
) (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic              setup_end,
  input wire logic              in_token,
  input wire logic              hs_ack,
  input wire logic              status_token,
  input wire logic              tx_valid,
  input wire logic [7:0]        tx_data,
  input wire logic              tx_last,
  input wire logic              tx_ready,
  input wire logic              tx_zlp,
  input wire logic              in_nak,
  input wire logic              status_ack,
  input wire logic              status_nak,
  input wire logic              setup_received_irq,
  input wire logic              ep_zero_in_irq,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              mem_rd
);
  logic [7:0] hi_q;
  logic       on_q;
  logic [6:0] cnt_q;
  wire logic  low_wr = reg_wr && reg_addr == ep0_autosend_pkg::ADDR_PTR_LOW;
  wire logic  take = tx_valid && tx_ready;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // approximate busy flag: a transfer runs from the start write to its status answer
  always_ff @(posedge sys_clk)
  begin
    if (rst || status_ack || setup_end)
      on_q <= 1'b0;
    else if (low_wr)
      on_q <= 1'b1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      hi_q <= 8'h00;
    else if (reg_wr && reg_addr == ep0_autosend_pkg::ADDR_PTR_HIGH)
      hi_q <= reg_wdata;
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst || (take && tx_last))
      cnt_q <= 7'h00;
    else if (take)
      cnt_q <= cnt_q + 7'h01;
  end
  sequence start_s;
    low_wr && !on_q;
  endsequence
  sequence fetch_s;
    mem_rd && mem_addr == {hi_q, $past(reg_wdata, 2)};
  endsequence
  start_fetch_a: assert property (start_s |-> ##2 fetch_s)
    else $error("transfer start did not read at the pointer");
  setup_irq_a: assert property (setup_end |=> setup_received_irq)
    else $error("setup irq missing after setup end");
  setup_cause_a: assert property (setup_received_irq |-> $past(setup_end))
    else $error("setup irq without setup end");
  in_irq_a: assert property (ep_zero_in_irq |-> $past(hs_ack))
    else $error("in irq without host ack");
  pkt_size_a: assert property (take |-> cnt_q < 7'h40)
    else $error("packet longer than 64 bytes");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte changed while stalled");
  last_valid_a: assert property (tx_last |-> tx_valid)
    else $error("last flag without valid byte");
  status_reply_a: assert property (status_token |=> status_ack != status_nak)
    else $error("status token not answered once");
  in_answer_a: assert property (in_token |-> ##[1:2] (tx_valid || in_nak || tx_zlp))
    else $error("in token not answered");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule
bind ep0_descriptor_autosend ep0_autosend_chk #(.ADDR_W(ADDR_W)) chk (
  .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .setup_end,
  .in_token, .hs_ack, .status_token, .tx_valid, .tx_data, .tx_last, .tx_ready, .tx_zlp,
  .in_nak, .status_ack, .status_nak, .setup_received_irq, .ep_zero_in_irq, .mem_addr, .mem_rd
);
`default_nettype wire

//--- verification/ep0_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ep0_host_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic       err,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  input  wire logic       tx_zlp,
  input  wire logic       in_nak,
  output logic            in_token,
  output logic            hs_ack,
  output logic            hs_timeout,
  output logic            tx_ready,
  output logic            done,
  output logic      [7:0] nbytes
);
  logic       armed;
  logic       rx_on;
  logic       fin;
  logic [1:0] slow;
  // refuses one byte slot in four so the stall path is exercised in every packet of four bytes or more
  assign tx_ready = rx_on && slow != 2'h0;
  assign fin = rx_on && (tx_zlp || (tx_valid && tx_ready && tx_last));
  always_ff @(posedge sys_clk)
  begin
    slow <= rst ? 2'h0 : slow + 2'h1;
    // a refused token is simply retried, as a real host does
    in_token <= !rst && armed && !rx_on && !in_token && !done;
    hs_ack <= fin && !err;
    hs_timeout <= fin && err;
    done <= fin;
    armed <= !rst && (armed || go) && !fin;
    if (rst || in_nak || fin)
      rx_on <= 1'b0;
    else if (in_token)
      rx_on <= 1'b1;
    if (in_token)
      nbytes <= 8'h00;
    else if (tx_valid && tx_ready)
      nbytes <= nbytes + 8'h01;
  end
endmodule
`default_nettype wire

//--- verification/ep0_descriptor_autosend_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ep0_descriptor_autosend_tb;
  logic        sys_clk, rst, reg_wr, reg_rd, setup_wr, setup_end, status_token;
  logic        go, err, in_token, hs_ack, hs_timeout, tx_ready, done, tx_valid;
  logic        tx_last, tx_zlp, in_nak, status_ack, status_nak, mem_rd;
  logic        setup_received_irq, ep_zero_in_irq;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, setup_data, tx_data, nbytes, ep;
  logic [7:0]  mem_rdata = 8'h00;
  logic [7:0]  mem_img [0:255];
  logic [2:0]  setup_idx;
  logic [15:0] mem_addr;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;
  ep0_descriptor_autosend #(.ADDR_W(16)) uut (
    .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .setup_wr,
    .setup_idx, .setup_data, .setup_end, .in_token, .hs_ack, .hs_timeout, .status_token,
    .tx_valid, .tx_data, .tx_last, .tx_ready, .tx_zlp, .in_nak, .status_ack, .status_nak,
    .setup_received_irq, .ep_zero_in_irq, .mem_addr, .mem_rd, .mem_rdata
  );
  ep0_host_model host (
    .sys_clk, .rst, .go, .err, .tx_valid, .tx_last, .tx_zlp, .in_nak, .in_token, .hs_ack,
    .hs_timeout, .tx_ready, .done, .nbytes
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    mem_rdata <= mem_img[mem_addr[7:0]];
  always @(posedge sys_clk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      check({8'h00, tx_data}, {8'h00, mem_img[ep]});
      ep <= ep + 8'h01;
    end
  end
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    check({8'h00, reg_rdata}, exp);
  endtask
  task automatic stat(input logic [1:0] exp);
    @(posedge sys_clk);
    status_token <= 1'b1;
    @(posedge sys_clk);
    status_token <= 1'b0;
    @(negedge sys_clk);
    check({14'h0000, status_ack, status_nak}, {14'h0000, exp});
  endtask
  task automatic setup_pkt(input logic [7:0] b [8]);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      setup_wr <= 1'b1;
      setup_idx <= i[2:0];
      setup_data <= b[i];
    end
    @(posedge sys_clk);
    {setup_wr, setup_end} <= 2'b01;
    @(posedge sys_clk);
    setup_end <= 1'b0;
    @(negedge sys_clk);
    check({15'h0000, setup_received_irq}, 16'h0001);
  endtask
  task automatic get(input logic [7:0] rt, dt, base, input logic [15:0] req, tot,
                     input logic e);
    logic [15:0] rem;
    logic [7:0]  n;
    logic [7:0]  st;
    int          k;
    setup_pkt('{rt, 8'h06, 8'h00, dt, 8'h00, 8'h00, req[7:0], req[15:8]});
    stat(2'b01);
    rd(ep0_autosend_pkg::ADDR_SETUP_BASE + 8'h03, {8'h00, dt});
    rd(ep0_autosend_pkg::ADDR_CTRL, 16'h0003);
    wr(ep0_autosend_pkg::ADDR_CTRL, 8'h03);
    wr(ep0_autosend_pkg::ADDR_PTR_HIGH, 8'h12);
    wr(ep0_autosend_pkg::ADDR_PTR_LOW, base);
    rem = tot;
    st = base;
    err <= e;
    while (rem != 16'h0000)
    begin
      n = (rem > 16'h0040) ? 8'h40 : rem[7:0];
      ep <= st;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      for (k = 0; k < 400 && done !== 1'b1; k++)
        @(posedge sys_clk);
      check({8'h00, nbytes}, {8'h00, n});
      // a refused packet must come again from the same start
      if (err === 1'b1)
        err <= 1'b0;
      else
      begin
        rem = rem - {8'h00, n};
        st = st + n;
      end
    end
    stat(2'b10);
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    {reg_wr, reg_rd, setup_wr, setup_end, status_token, go, err} = 7'h00;
    {reg_addr, reg_wdata, setup_data, setup_idx} = 27'h0000000;
    for (int i = 0; i < 256; i++)
      mem_img[i] = i[7:0] ^ 8'hA5;
    {mem_img[8'h10], mem_img[8'h11]} = 16'h5B01;
    {mem_img[8'h80], mem_img[8'h81], mem_img[8'h82], mem_img[8'h83]} = 32'h09024600;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ep0_autosend_pkg::ADDR_CTRL, 16'h0002);
    rd(8'h20, 16'h0000);
    wr(ep0_autosend_pkg::ADDR_PTR_HIGH, 8'h34);
    rd(ep0_autosend_pkg::ADDR_CTRL, 16'h0002);
    get(8'h80, 8'h01, 8'h10, 16'h00FF, 16'h005B, 1'b1);
    get(8'hC0, 8'h00, 8'h10, 16'h0002, 16'h0002, 1'b0);
    get(8'h80, 8'h02, 8'h80, 16'h0100, 16'h0046, 1'b0);
    get(8'h80, 8'h03, 8'h10, 16'h0040, 16'h0040, 1'b0);
    report_and_stop;
  end
endmodule
`default_nettype wire
